// ==== logic/bfg_pkg.sv ====
// Purpose: constants and carriers for the boot flash section guard
// Assumes: word-addressed flash, fixed concurrent/no-concurrent split at a page boundary
// Notes: lock bits use 1 = unprogrammed, 0 = programmed
// Behaviour
// - store ops from application part ignored
// - boot code may store to any page
// - boot boundary comes from size fuses
// - stall depends only on target page section
// - concurrent-section target: CPU runs, reads limited
// - fixed-section target: CPU stalled whole operation
// - boot part always inside fixed section
// - busy flag set while concurrent section blocked
// - boot lock bits cleared only by chip erase; here reset also reloads all lock bits to 1
// - general chip lock modes ignored here
// - app pair 11: no restriction
// - app pair 10: block stores to application
// - app pair 00: block stores and boot loads
// - app pair 01: block boot loads, mask vectors
// - boot pair 11: no restriction
// - boot pair 10: block stores to boot
// - boot pair 00: block stores and app loads
// - boot pair 01: block app loads, mask vectors
package bfg_pkg;

    localparam int ADDR_W = 15;
    localparam int PAGE_W = 7;
    localparam int FUSE_W = 2;
    localparam int DATA_W = 16;
    // first word of the no-read-while-write part
    localparam logic [14:0] FIXED_BASE = 15'h7000;
    // boot part start per fuse code 00..11, all at or above FIXED_BASE
    localparam logic [14:0] BOOT_BASE_0 = 15'h7000;
    localparam logic [14:0] BOOT_BASE_1 = 15'h7800;
    localparam logic [14:0] BOOT_BASE_2 = 15'h7C00;
    localparam logic [14:0] BOOT_BASE_3 = 15'h7E00;
    localparam logic [15:0] BLOCKED_DATA = 16'hFFFF;
    localparam logic [1:0] LOCK_NONE = 2'h3;
    localparam int OP_CYCLES = 8;

    typedef struct packed {
        logic store_pgm;    // store_program_op write (erase/write page)
        logic load_rd;      // load_program_read
        logic [14:0] addr;  // target word address
    } bfg_req_s;

    typedef enum logic [1:0] {BFG_IDLE, BFG_BUSY} bfg_state_e;

endpackage

// ==== logic/bfg_guard.sv ====
// Purpose: lock and read-while-write guard for self-programmed flash
// Assumes: single core clock; fuses and lock bits stable except via ports
// Notes: flash array itself sits outside; this block grants and stalls
`timescale 1ns/1ps
`default_nettype none
module bfg_guard #(
    parameter int OP_LEN = bfg_pkg::OP_CYCLES
) (
    input wire logic core_clk,                  // 40 MHz clock
    input wire logic rst_n,                     // async reset, active low
    input wire logic clk_en,                    // freezes state when low
    input wire logic [1:0] boot_size_fuses,     // boot part size code
    input wire logic [14:0] fetch_addr,         // current instruction address
    input wire bfg_pkg::bfg_req_s req,          // store/load request
    input wire logic lock_wr,                   // software lock-bit program strobe
    input wire logic [3:0] lock_wdata,          // {boot_hi,boot_lo,app_hi,app_lo}
    input wire logic chip_erase,                // full chip erase strobe
    input wire logic busy_clear,                // software clear of busy flag
    input wire logic [15:0] flash_rdata,        // data from array
    output logic store_go,                      // granted store pulse to array
    output logic cpu_stall,                     // core halt
    output logic rww_blocked,                   // concurrent section unreadable
    output logic concurrent_section_busy_flag,  // status bit in control reg
    output logic [15:0] load_data,              // load read result
    output logic load_ok,                       // load granted
    output logic boot_irq_mask,                 // mask boot-vectored irqs
    output logic app_irq_mask,                  // mask app-vectored irqs
    output logic [3:0] lock_bits                // current lock bits
);
    initial begin
        if (OP_LEN < 1 || OP_LEN > 255)
            $error("OP_LEN out of range");
    end

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_s1_q, rst_sync_n;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_sync_n <= rst_s1_q;
        end
    end

    // ----------------------------------------
    // section decode
    // ----------------------------------------
    function automatic logic [14:0] boot_base(input logic [1:0] f);
        logic [14:0] b;
        b = bfg_pkg::BOOT_BASE_0;
        case (f)
            2'h0: b = bfg_pkg::BOOT_BASE_0;
            2'h1: b = bfg_pkg::BOOT_BASE_1;
            2'h2: b = bfg_pkg::BOOT_BASE_2;
            default: b = bfg_pkg::BOOT_BASE_3;
        endcase
        return b;
    endfunction

    logic [14:0] bb;
    logic from_boot, tgt_boot, tgt_fixed, fetch_conc;
    assign bb = boot_base(boot_size_fuses);
    assign from_boot = fetch_addr >= bb;
    assign tgt_boot = req.addr >= bb;
    assign tgt_fixed = req.addr >= bfg_pkg::FIXED_BASE;
    assign fetch_conc = fetch_addr < bfg_pkg::FIXED_BASE;

    // ----------------------------------------
    // lock bits
    // ----------------------------------------
    logic [3:0] lock_q;
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            lock_q <= 4'hF;
        else if (clk_en)
        begin
            if (chip_erase)
                lock_q <= 4'hF;
            else if (lock_wr)
                lock_q <= lock_q & lock_wdata; // only programs bits
        end
    end
    assign lock_bits = lock_q;

    logic [1:0] app_pair, boot_pair;
    assign app_pair = lock_q[1:0];
    assign boot_pair = lock_q[3:2];

    // general chip lock modes have no input here at all
    logic store_lock, load_lock, store_ok, load_allowed;
    always_comb
    begin
        store_lock = 1'b0;
        load_lock = 1'b0;
        if (tgt_boot)
        begin
            store_lock = !boot_pair[0];
            load_lock = !from_boot && !boot_pair[1];
        end
        else
        begin
            store_lock = !app_pair[0];
            load_lock = from_boot && !app_pair[1];
        end
    end
    // store from application is ignored; from boot any page
    assign store_ok = req.store_pgm && from_boot && !store_lock;
    assign load_allowed = !load_lock;

    // ----------------------------------------
    // operation sequencer
    // ----------------------------------------
    bfg_pkg::bfg_state_e st_q;
    logic [7:0] cnt_q;
    logic fixed_q;
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            st_q <= bfg_pkg::BFG_IDLE;
            cnt_q <= 8'h00;
            fixed_q <= 1'b0;
        end
        else if (clk_en)
        begin
            case (st_q)
                bfg_pkg::BFG_IDLE:
                    if (store_ok) // blocked store changes nothing
                    begin
                        st_q <= bfg_pkg::BFG_BUSY;
                        cnt_q <= 8'(OP_LEN - 1);
                        fixed_q <= tgt_fixed;
                    end
                bfg_pkg::BFG_BUSY:
                    if (cnt_q == 8'h00)
                        st_q <= bfg_pkg::BFG_IDLE;
                    else
                        cnt_q <= cnt_q - 8'h01;
                default: st_q <= bfg_pkg::BFG_IDLE;
            endcase
        end
    end
    logic busy;
    assign busy = st_q == bfg_pkg::BFG_BUSY;
    assign store_go = clk_en && st_q == bfg_pkg::BFG_IDLE && store_ok;
    assign cpu_stall = busy && fixed_q;
    // conc target: core runs, fetches from concurrent section are not served
    assign rww_blocked = busy && !fixed_q;

    // busy flag: set by op start, held until software clears after finish
    logic flag_q;
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            flag_q <= 1'b0;
        else if (clk_en)
        begin
            if (store_go)
                flag_q <= 1'b1; // set wins over clear
            else if (busy_clear && !busy)
                flag_q <= 1'b0;
        end
    end
    assign concurrent_section_busy_flag = flag_q;

    // ----------------------------------------
    // load path
    // ----------------------------------------
    logic [15:0] ld_q;
    logic ld_ok_q;
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            ld_q <= 16'h0000;
            ld_ok_q <= 1'b0;
        end
        else if (clk_en)
        begin
            ld_ok_q <= req.load_rd && load_allowed;
            if (req.load_rd)
                ld_q <= load_allowed ? flash_rdata : bfg_pkg::BLOCKED_DATA;
        end
    end
    assign load_data = ld_q;
    assign load_ok = ld_ok_q;

    // vector masking only applies in load-restricting modes
    assign boot_irq_mask = !from_boot && !app_pair[1];
    assign app_irq_mask = from_boot && !boot_pair[1];
    logic unused;
    assign unused = fetch_conc;
endmodule // bfg_guard
`default_nettype wire

// ==== sim/bfg_chk.sv ====
// Purpose: port checker for bfg_guard
// Assumes: clk_en held high by the bench
// Notes: boot base follows the size fuses
`timescale 1ns/1ps
`default_nettype none
module bfg_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] boot_size_fuses,
    input wire logic [14:0] fetch_addr,
    input wire bfg_pkg::bfg_req_s req,
    input wire logic chip_erase,
    input wire logic store_go,
    input wire logic cpu_stall,
    input wire logic rww_blocked,
    input wire logic concurrent_section_busy_flag,
    input wire logic [15:0] load_data,
    input wire logic load_ok,
    input wire logic [3:0] lock_bits
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [14:0] bb;
    logic rd_lk;
    assign bb = boot_size_fuses[1] ? (boot_size_fuses[0] ? 15'h7E00 : 15'h7C00)
        : (boot_size_fuses[0] ? 15'h7800 : 15'h7000);
    assign rd_lk = fetch_addr >= bb ? (req.addr < bb && !lock_bits[1])
        : (req.addr >= bb && !lock_bits[3]);
    property p_app; req.store_pgm && fetch_addr < bb |-> !store_go; endproperty
    a_app: assert property (p_app) else $error("app store granted");
    property p_fix; store_go && req.addr >= 15'h7000 |=> cpu_stall [*2]; endproperty
    a_fix: assert property (p_fix) else $error("no stall");
    property p_rww; store_go && req.addr < 15'h7000 |=> rww_blocked && !cpu_stall; endproperty
    a_rww: assert property (p_rww) else $error("bad rww");
    property p_flg; rww_blocked |-> concurrent_section_busy_flag; endproperty
    a_flg: assert property (p_flg) else $error("flag low");
    property p_alk; store_go && req.addr < bb |-> lock_bits[0]; endproperty
    a_alk: assert property (p_alk) else $error("app locked");
    property p_blk; store_go && req.addr >= bb |-> lock_bits[2]; endproperty
    a_blk: assert property (p_blk) else $error("boot locked");
    property p_lrd; req.load_rd && rd_lk |=> !load_ok && load_data == 16'hFFFF; endproperty
    a_lrd: assert property (p_lrd) else $error("load leak");
    property p_erz; (lock_bits & ~$past(lock_bits)) != 4'h0 |-> $past(chip_erase); endproperty
    a_erz: assert property (p_erz) else $error("lock cleared");
endmodule // bfg_chk
bind bfg_guard bfg_chk i_bfg_chk (.core_clk, .rst_n, .boot_size_fuses, .fetch_addr, .req,
    .chip_erase, .store_go, .cpu_stall, .rww_blocked, .concurrent_section_busy_flag,
    .load_data, .load_ok, .lock_bits);
`default_nettype wire

// ==== sim/bfg_core_model.sv ====
// Purpose: boot loader core issuing stores and loads
// Assumes: one request at a time
// Notes: waits out busy, then clears the flag
`timescale 1ns/1ps
`default_nettype none
module bfg_core_model (
    input wire logic core_clk,          // clock
    input wire logic busy,              // stall or rww blocked
    input wire logic load_ok,           // load granted
    input wire logic [15:0] load_data,  // load result
    output var bfg_pkg::bfg_req_s req,  // request
    output logic [14:0] fetch_addr,     // fetch address
    output logic busy_clear             // flag clear
);
    initial {req, fetch_addr, busy_clear} = '0;
    task automatic store(input logic [14:0] f, input logic [14:0] a);
        @(posedge core_clk);
        fetch_addr <= f;
        req <= '{1'b1, 1'b0, a};
        @(posedge core_clk);
        req.store_pgm <= 1'b0;
        // stays on fixed-part code; touching the busy part would be undefined
        repeat (20) @(negedge core_clk) if (!busy) break;
        @(posedge core_clk);
        busy_clear <= 1'b1;
        @(posedge core_clk);
        busy_clear <= 1'b0;
    endtask
    task automatic load(input logic [14:0] f, a, output logic ok, output logic [15:0] d);
        @(posedge core_clk);
        fetch_addr <= f;
        req <= '{1'b0, 1'b1, a};
        @(posedge core_clk);
        req.load_rd <= 1'b0;
        @(negedge core_clk);
        ok = load_ok;
        d = load_data;
    endtask
endmodule // bfg_core_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: self-checking bench for bfg_guard
// Assumes: clk_en held high
// Notes: grant and busy cycles counted per store
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [14:0] B = 15'h7E00, A = 15'h0200, F = 15'h0100;
    logic core_clk, rst_n, lock_wr, chip_erase, ok, store_go, cpu_stall, rww_blocked;
    logic flag, load_ok, busy_clear, boot_irq_mask, app_irq_mask;
    logic [1:0] fuses;
    logic [3:0] lock_wdata, lock_bits;
    logic [15:0] rdata, load_data, d;
    logic [14:0] fetch_addr;
    bfg_pkg::bfg_req_s req;
    int fails = 0, check_count = 0, cyc = 0, go_n, st_n, rb_n;
    bfg_guard i_bfg_guard (.core_clk, .rst_n, .clk_en(1'b1), .boot_size_fuses(fuses),
        .fetch_addr, .req, .lock_wr, .lock_wdata, .chip_erase, .busy_clear,
        .flash_rdata(rdata), .store_go, .cpu_stall, .rww_blocked,
        .concurrent_section_busy_flag(flag), .load_data, .load_ok,
        .boot_irq_mask, .app_irq_mask, .lock_bits);
    bfg_core_model i_bfg_core_model (.core_clk, .busy(cpu_stall | rww_blocked), .load_ok,
        .load_data, .req, .fetch_addr, .busy_clear);
    initial
    begin
        core_clk = 0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        go_n += store_go;
        st_n += cpu_stall;
        rb_n += rww_blocked;
        if (++cyc == 4000)
        begin
            fails++;
            test_done;
        end
    end
    task automatic chk(input bit c, input string m);
        check_count++;
        if (!c)
        begin
            fails++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task automatic st(input logic [14:0] f, a, input int g, s, r);
        @(negedge core_clk);
        {go_n, st_n, rb_n} = '0;
        i_bfg_core_model.store(f, a);
        @(negedge core_clk);
        chk(go_n == g && st_n == s && rb_n == r && flag === 1'b0, "store");
    endtask
    task automatic ld(input logic [14:0] f, a, input bit e);
        i_bfg_core_model.load(f, a, ok, d);
        chk(ok === e && d === (e ? rdata : bfg_pkg::BLOCKED_DATA), "load");
    endtask
    task automatic lk(input logic [3:0] w, input bit erase);
        @(posedge core_clk);
        lock_wr <= !erase;
        lock_wdata <= w;
        chip_erase <= erase;
        @(posedge core_clk);
        lock_wr <= 1'b0;
        chip_erase <= 1'b0;
        // lock bits update on this edge; look once they have settled
        @(negedge core_clk);
    endtask
    task automatic t_sections;
        chk(lock_bits === 4'hF && flag === 1'b0 && load_data === 16'h0, "reset");
        st(F, A, 0, 0, 0);
        fuses <= 2'h2;
        st(15'h7800, A, 0, 0, 0);
        fuses <= 2'h1;
        st(15'h7800, A, 1, 0, 8);
        st(B, B, 1, 8, 0);
        st(B, 15'h7000, 1, 8, 0);
        ld(B, A, 1);
        ld(F, B, 1);
        chk(boot_irq_mask === 1'b0 && app_irq_mask === 1'b0, "mask open");
    endtask
    task automatic t_app_locks;
        lk(4'hD, 0);
        st(B, A, 1, 0, 8);
        ld(B, A, 0);
        ld(F, A, 1);
        chk(boot_irq_mask === 1'b1, "boot mask");
        lk(4'hE, 0);
        chk(lock_bits === 4'hC, "and in");
        st(B, A, 0, 0, 0);
        lk(4'hF, 1);
        lk(4'hE, 0);
        st(B, A, 0, 0, 0);
        ld(B, A, 1);
    endtask
    task automatic t_boot_locks;
        lk(4'hF, 1);
        chk(lock_bits === 4'hF, "erase");
        lk(4'h7, 0);
        st(B, B, 1, 8, 0);
        chk(app_irq_mask === 1'b1, "app mask");
        ld(F, B, 0);
        lk(4'hB, 0);
        st(B, B, 0, 0, 0);
        ld(F, B, 0);
        lk(4'hF, 1);
        lk(4'hB, 0);
        st(B, B, 0, 0, 0);
        ld(F, B, 1);
    endtask
    task automatic test_done;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        {rst_n, lock_wr, chip_erase, lock_wdata, fuses} = '0;
        rdata = 16'h1234;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_sections;
        t_app_locks;
        t_boot_locks;
        test_done;
    end
endmodule // testbench
`default_nettype wire
